//--- pkg/timer_pkg.sv
// constants, field layouts and carrier types for the timer block
package timer_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_FORCE_PWM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ACC        = 8'h04;
  localparam logic [7:0] OFS_DUTY       = 8'h08;
  localparam logic [7:0] OFS_DBUF       = 8'h0C;
  localparam logic [7:0] OFS_PCNT       = 8'h10;
  localparam logic [7:0] OFS_SHARED     = 8'h14;
  localparam logic [7:0] OFS_ACTION     = 8'h18;
  localparam logic [7:0] OFS_DIR        = 8'h1C;
  localparam logic [7:0] OFS_FLAGS      = 8'h20;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int          NCMP        = 5;
  localparam int          TAP_W       = 9;
  localparam int          TAP_DIV512  = 8;
  localparam int          FLG_EDGE    = 0;
  localparam int          FLG_OVF     = 1;
  localparam logic [2:0]  PPR_EXT     = 3'h7;
  localparam logic [1:0]  GCLK_DIV512 = 2'h0;
  localparam logic [1:0]  GCLK_CC     = 2'h1;
  localparam logic [1:0]  GCLK_EXT    = 2'h2;
  localparam logic [7:0]  FAST_END    = 8'hFF;
  localparam logic [14:0] SLOW_END    = 15'h7FFF;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] PCNT_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic       pwm_enable;
    logic       speed_select_a;
    logic       speed_select_b;
    logic       clk_out;
    logic [2:0] pwm_prescale_select;
  } pwm_ctl_t;

  typedef struct packed {
    logic       shared_function_select;
    logic       accumulator_mode_select;
    logic       accumulator_edge_polarity;
    logic       acc_enable;
    logic [1:0] gated_clock_select;
  } acc_ctl_t;

endpackage

//--- logic/prescale_taps.sv
// system clock divider chain with one tick per tap
`timescale 1ns/1ps
`default_nettype none
module prescale_taps #(
  parameter int WIDTH = 9
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  output logic      [WIDTH-1:0] tick_out
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] tick_nxt;

  always_comb begin
    logic run;
    run = 1'b1;
    cnt_nxt = cnt_r + WIDTH'(1);
    for (int k = 0; k < WIDTH; k++) begin
      run = run & cnt_r[k];
      tick_nxt[k] = run;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      tick_out <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

//--- logic/timer_compare_accum_pwm.sv
// compare actions, shared capture/compare, pulse accumulator and two-channel pwm
`timescale 1ns/1ps
`default_nettype none
module timer_compare_accum_pwm
  import timer_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [4:0]  compare_match_in,
  input  wire logic        capture_strobe_in,
  input  wire logic [15:0] capture_value_in,
  input  wire logic        cc_clock_tick_in,
  input  wire logic        timer_overflow_in,
  input  wire logic        freeze_in,
  input  wire logic        accumulator_input_pin_in,
  input  wire logic        ext_clock_pin_in,
  output logic      [4:0]  cmp_pin_out,
  output logic      [4:0]  cmp_pin_oe_out,
  output logic      [4:0]  compare_flag_out,
  output logic      [15:0] shared_compare_value_out,
  output logic             shared_is_capture_out,
  output logic             pwm_a_out,
  output logic             pwm_b_out,
  output logic             accumulator_edge_irq_out,
  output logic             accumulator_overflow_irq_out
);

  // ****************************************
  // state
  // ****************************************
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  pwm_ctl_t    pwm_ctl_r, pwm_ctl_nxt;
  logic [1:0]  force_high_r, force_high_nxt;
  logic [4:0]  mask_r, mask_nxt;
  logic [4:0]  data_r, data_nxt;
  logic [4:0]  dir_r, dir_nxt;
  logic [15:0] shared_r, shared_nxt;
  logic [4:0]  fpend_r, fpend_nxt;
  logic [4:0]  pin_r, pin_nxt;
  logic [4:0]  cflag_r, cflag_nxt;
  acc_ctl_t    acc_ctl_r, acc_ctl_nxt;
  logic [7:0]  acc_cnt_r, acc_cnt_nxt;
  logic [1:0]  flags_r, flags_nxt;
  logic [1:0]  ien_r, ien_nxt;
  logic [7:0]  duty_a_r, duty_a_nxt;
  logic [7:0]  duty_b_r, duty_b_nxt;
  logic [7:0]  buf_a_r, buf_a_nxt;
  logic [7:0]  buf_b_r, buf_b_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  logic [1:0]  fact_r, fact_nxt;
  logic [1:0]  pwm_pin_r, pwm_pin_nxt;
  logic        pai_s1, pai_s2, pai_s3;
  logic        pck_s1, pck_s2, pck_s3;

  // ****************************************
  // shared decode
  // ****************************************
  logic [TAP_W-1:0] tick;
  logic        wr_go;
  logic        req;
  logic [31:0] wd;
  logic [4:0]  act;
  logic        pck_rise;
  logic        pwm_tick;
  logic        end_a, end_b;
  logic [7:0]  slice_a, slice_b;
  logic        sel_edge, gate_trail, gate_on, gclk;
  logic        acc_inc, acc_evt;

  prescale_taps #(
    .WIDTH (TAP_W)
  ) u_taps (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  assign req      = avs_read_in | avs_write_in;
  assign wr_go    = avs_write_in & ack_r;
  assign wd       = avs_writedata_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out    = rdata_r;

  function automatic logic wsel(input logic [7:0] ofs, input int lane);
    wsel = wr_go && (avs_address_in == ofs) && avs_byteenable_in[lane];
  endfunction

  // ****************************************
  // register bus
  // ****************************************
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (req && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (avs_address_in == OFS_FORCE_PWM_CONTROL) begin
        rdata_nxt[15:0] = {6'h00, pwm_pin_r, 1'b0, pwm_ctl_r};
      end else if (avs_address_in == OFS_ACC) begin
        rdata_nxt[15:0] = {pai_s2, pck_s2, acc_ctl_r, acc_cnt_r};
      end else if (avs_address_in == OFS_DUTY) begin
        rdata_nxt[15:0] = {duty_a_r, duty_b_r};
      end else if (avs_address_in == OFS_DBUF) begin
        rdata_nxt[15:0] = {buf_a_r, buf_b_r};
      end else if (avs_address_in == OFS_PCNT) begin
        rdata_nxt[15:0] = pcnt_r;
      end else if (avs_address_in == OFS_SHARED) begin
        rdata_nxt[15:0] = shared_r;
      end else if (avs_address_in == OFS_ACTION) begin
        rdata_nxt[15:0] = {3'h0, mask_r, 3'h0, data_r};
      end else if (avs_address_in == OFS_DIR) begin
        rdata_nxt[15:0] = {11'h000, dir_r};
      end else if (avs_address_in == OFS_FLAGS) begin
        rdata_nxt[15:0] = {6'h00, ien_r, 6'h00, flags_r};
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // compare actions and shared register
  // ****************************************
  assign act = compare_match_in | fpend_r;
  assign shared_is_capture_out = acc_ctl_r.shared_function_select;
  assign shared_compare_value_out = shared_r;
  assign cmp_pin_out = pin_r;
  assign cmp_pin_oe_out = dir_r & {~acc_ctl_r.shared_function_select, 4'hF};
  assign compare_flag_out = cflag_r;

  always_comb begin
    mask_nxt = mask_r;
    data_nxt = data_r;
    dir_nxt = dir_r;
    shared_nxt = shared_r;
    fpend_nxt = 5'h00;
    cflag_nxt = compare_match_in;
    pin_nxt = pin_r;
    if (wsel(OFS_ACTION, 0)) begin
      data_nxt = wd[4:0];
    end
    if (wsel(OFS_ACTION, 1)) begin
      mask_nxt = wd[12:8];
    end
    if (wsel(OFS_DIR, 0)) begin
      dir_nxt = wd[4:0];
    end
    if (wsel(OFS_FORCE_PWM_CONTROL, 1)) begin
      for (int i = 0; i < NCMP; i++) begin
        fpend_nxt[i] = wd[15-i];
      end
    end
    if (!acc_ctl_r.shared_function_select || freeze_in) begin
      if (wsel(OFS_SHARED, 0)) begin
        shared_nxt[7:0] = wd[7:0];
      end
      if (wsel(OFS_SHARED, 1)) begin
        shared_nxt[15:8] = wd[15:8];
      end
    end
    if (acc_ctl_r.shared_function_select && capture_strobe_in) begin
      shared_nxt = capture_value_in;
    end
    for (int i = 1; i < NCMP; i++) begin
      if (act[i] && !(i == NCMP - 1 && acc_ctl_r.shared_function_select)) begin
        pin_nxt[i] = ~pin_r[i];
      end
    end
    if (act[0]) begin
      pin_nxt = (pin_nxt & ~mask_r) | (data_r & mask_r);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mask_r <= 5'h00;
      data_r <= 5'h00;
      dir_r <= 5'h00;
      shared_r <= 16'h0000;
      fpend_r <= 5'h00;
      cflag_r <= 5'h00;
      pin_r <= 5'h00;
    end else begin
      mask_r <= mask_nxt;
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      shared_r <= shared_nxt;
      fpend_r <= fpend_nxt;
      cflag_r <= cflag_nxt;
      pin_r <= pin_nxt;
    end
  end

  // ****************************************
  // pulse accumulator
  // ****************************************
  assign pck_rise   = pck_s2 & ~pck_s3;
  assign gate_on    = pai_s2 == acc_ctl_r.accumulator_edge_polarity;
  assign sel_edge   = gate_on & (pai_s2 != pai_s3);
  assign gate_trail = ~gate_on & (pai_s2 != pai_s3);
  assign accumulator_edge_irq_out     = flags_r[FLG_EDGE] & ien_r[FLG_EDGE];
  assign accumulator_overflow_irq_out = flags_r[FLG_OVF] & ien_r[FLG_OVF];

  always_comb begin
    case (acc_ctl_r.gated_clock_select)
      GCLK_DIV512: gclk = tick[TAP_DIV512];
      GCLK_CC:     gclk = cc_clock_tick_in;
      GCLK_EXT:    gclk = pck_rise;
      default:     gclk = timer_overflow_in;
    endcase
    acc_inc = 1'b0;
    acc_evt = 1'b0;
    if (acc_ctl_r.acc_enable) begin
      if (acc_ctl_r.accumulator_mode_select) begin
        acc_inc = gate_on & gclk;
        acc_evt = gate_trail;
      end else begin
        acc_inc = sel_edge;
        acc_evt = sel_edge;
      end
    end
    acc_ctl_nxt = acc_ctl_r;
    acc_cnt_nxt = acc_inc ? acc_cnt_r + 8'h01 : acc_cnt_r;
    ien_nxt = ien_r;
    flags_nxt = flags_r;
    if (wsel(OFS_ACC, 1)) begin
      acc_ctl_nxt = wd[13:8];
    end
    if (wsel(OFS_ACC, 0)) begin
      acc_cnt_nxt = wd[7:0];
    end
    if (wsel(OFS_FLAGS, 1)) begin
      ien_nxt = wd[9:8];
    end
    if (wsel(OFS_FLAGS, 0)) begin
      flags_nxt = flags_r & ~wd[1:0];
    end
    if (acc_evt) begin
      flags_nxt[FLG_EDGE] = 1'b1;
    end
    if (acc_inc && acc_cnt_r == CNT_MAX) begin
      flags_nxt[FLG_OVF] = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ctl_r <= '0;
      acc_cnt_r <= BYTE_RST;
      ien_r <= 2'h0;
      flags_r <= 2'h0;
      pai_s1 <= 1'b0;
      pai_s2 <= 1'b0;
      pai_s3 <= 1'b0;
      pck_s1 <= 1'b0;
      pck_s2 <= 1'b0;
      pck_s3 <= 1'b0;
    end else begin
      acc_ctl_r <= acc_ctl_nxt;
      acc_cnt_r <= acc_cnt_nxt;
      ien_r <= ien_nxt;
      flags_r <= flags_nxt;
      pai_s1 <= accumulator_input_pin_in;
      pai_s2 <= pai_s1;
      pai_s3 <= pai_s2;
      pck_s1 <= ext_clock_pin_in;
      pck_s2 <= pck_s1;
      pck_s3 <= pck_s2;
    end
  end

  // ****************************************
  // pwm unit
  // ****************************************
  assign pwm_tick = (pwm_ctl_r.pwm_prescale_select == PPR_EXT) ? pck_rise
                  : tick[pwm_ctl_r.pwm_prescale_select];
  assign slice_a = pwm_ctl_r.speed_select_a ? pcnt_r[14:7] : pcnt_r[7:0];
  assign slice_b = pwm_ctl_r.speed_select_b ? pcnt_r[14:7] : pcnt_r[7:0];
  assign end_a = pwm_tick & (pwm_ctl_r.speed_select_a ? pcnt_r[14:0] == SLOW_END : pcnt_r[7:0] == FAST_END);
  assign end_b = pwm_tick & (pwm_ctl_r.speed_select_b ? pcnt_r[14:0] == SLOW_END : pcnt_r[7:0] == FAST_END);
  assign pwm_a_out = pwm_pin_r[1];
  assign pwm_b_out = pwm_pin_r[0];

  always_comb begin
    pwm_ctl_nxt = pwm_ctl_r;
    force_high_nxt = force_high_r;
    duty_a_nxt = duty_a_r;
    duty_b_nxt = duty_b_r;
    pcnt_nxt = pwm_tick ? pcnt_r + 16'h0001 : pcnt_r;
    if (wsel(OFS_FORCE_PWM_CONTROL, 0)) begin
      pwm_ctl_nxt = wd[6:0];
    end
    if (wsel(OFS_FORCE_PWM_CONTROL, 1)) begin
      force_high_nxt = wd[9:8];
    end
    if (wsel(OFS_DUTY, 1)) begin
      duty_a_nxt = wd[15:8];
    end
    if (wsel(OFS_DUTY, 0)) begin
      duty_b_nxt = wd[7:0];
    end
    if (freeze_in && wsel(OFS_PCNT, 0)) begin
      pcnt_nxt[7:0] = wd[7:0];
    end
    if (freeze_in && wsel(OFS_PCNT, 1)) begin
      pcnt_nxt[15:8] = wd[15:8];
    end
    buf_a_nxt = end_a ? duty_a_r : buf_a_r;
    buf_b_nxt = end_b ? duty_b_r : buf_b_r;
    fact_nxt[1] = end_a ? force_high_r[1] : fact_r[1];
    fact_nxt[0] = end_b ? force_high_r[0] : fact_r[0];
    if (!pwm_ctl_r.pwm_enable) begin
      pwm_pin_nxt = force_high_r;
    end else begin
      pwm_pin_nxt[1] = fact_r[1] | (slice_a < buf_a_r);
      pwm_pin_nxt[0] = fact_r[0] | (slice_b < buf_b_r);
      if (pwm_ctl_r.clk_out) begin
        pwm_pin_nxt[1] = pwm_tick;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_ctl_r <= '0;
      force_high_r <= 2'h0;
      duty_a_r <= BYTE_RST;
      duty_b_r <= BYTE_RST;
      buf_a_r <= BYTE_RST;
      buf_b_r <= BYTE_RST;
      pcnt_r <= PCNT_RST;
      fact_r <= 2'h0;
      pwm_pin_r <= 2'h0;
    end else begin
      pwm_ctl_r <= pwm_ctl_nxt;
      force_high_r <= force_high_nxt;
      duty_a_r <= duty_a_nxt;
      duty_b_r <= duty_b_nxt;
      buf_a_r <= buf_a_nxt;
      buf_b_r <= buf_b_nxt;
      pcnt_r <= pcnt_nxt;
      fact_r <= fact_nxt;
      pwm_pin_r <= pwm_pin_nxt;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_primary_action;
    act[0] |=> ((pin_r & $past(mask_r)) == ($past(data_r) & $past(mask_r)));
  endproperty
  a_primary_action: assert property (p_primary_action) else $error("primary action wrong");

  property p_primary_wins;
    act[0] && act[1] && mask_r[1] |=> pin_r[1] == $past(data_r[1]);
  endproperty
  a_primary_wins: assert property (p_primary_wins) else $error("primary did not win");

  property p_other_toggles;
    act[1] && !act[0] |=> pin_r[1] != $past(pin_r[1]);
  endproperty
  a_other_toggles: assert property (p_other_toggles) else $error("no toggle");

  property p_force_no_flag;
    fpend_r[2] && !compare_match_in[2] |=> !compare_flag_out[2];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag");

  property p_force_clears;
    fpend_r != 5'h00 |=> fpend_r == 5'h00;
  endproperty
  a_force_clears: assert property (p_force_clears) else $error("force stuck");

  property p_capture_locked;
    wsel(OFS_SHARED, 0) && acc_ctl_r.shared_function_select && !freeze_in && !capture_strobe_in
      |=> $stable(shared_r);
  endproperty
  a_capture_locked: assert property (p_capture_locked) else $error("capture reg written");

  property p_overflow_flag;
    acc_inc && acc_cnt_r == CNT_MAX |=> flags_r[FLG_OVF] && accumulator_overflow_irq_out == ien_r[FLG_OVF];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow missed");

  property p_buffer_load;
    end_a |=> buf_a_r == $past(duty_a_r);
  endproperty
  a_buffer_load: assert property (p_buffer_load) else $error("buffer not loaded");

  property p_duty_zero;
    pwm_ctl_r.pwm_enable && !pwm_ctl_r.clk_out && !fact_r[1] && buf_a_r == 8'h00 |=> !pwm_a_out;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty not low");

  c_force: cover property (fpend_r[0] && !compare_match_in[0] ##1 (pin_r & mask_r) == (data_r & mask_r));
  c_pwm_end: cover property (end_a && pwm_ctl_r.pwm_enable);
  c_acc_wrap: cover property (acc_inc && acc_cnt_r == CNT_MAX);
endmodule
`default_nettype wire

//--- bench/pin_board.sv
// board model driving the accumulator and external clock pins
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       start_in,
  input  wire logic [7:0] count_in,
  output logic            pin_out,
  output logic            busy_out
);
  logic [9:0] left_r;
  logic [9:0] left_nxt;
  always_comb begin
    left_nxt = (left_r != 10'h000) ? left_r - 10'h001 : left_r;
    if (start_in) begin
      left_nxt = {count_in, 2'b00};
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      left_r <= 10'h000;
    end else begin
      left_r <= left_nxt;
    end
  end
  // two high and two low cycles per pulse, idle low
  assign pin_out  = left_r[1];
  assign busy_out = (left_r != 10'h000);
endmodule
`default_nettype wire

//--- bench/timer_compare_accum_pwm_tb.sv
// random self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module timer_compare_accum_pwm_tb;
  import timer_pkg::*;
  localparam logic [31:0] all_bits = 32'hFFFFFFFF;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [4:0]  match = 5'h00;
  logic        frz = 1'b0;
  logic        cap = 1'b0;
  logic [15:0] capv = 16'h0000;
  logic        go = 1'b0;
  logic [7:0]  npulse = 8'h00;
  logic        pin, busy, is_cap, pa, pb, irq_e, irq_o;
  logic [4:0]  pins, oe, flags;
  logic [15:0] shval;
  int          err_count = 0;
  int          comparisons = 0;

  always #25 clock_in = ~clock_in;

  timer_compare_accum_pwm i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .compare_match_in(match),
    .capture_strobe_in(cap), .capture_value_in(capv), .cc_clock_tick_in(1'b0),
    .timer_overflow_in(1'b0), .freeze_in(frz), .accumulator_input_pin_in(pin),
    .ext_clock_pin_in(pin), .cmp_pin_out(pins), .cmp_pin_oe_out(oe),
    .compare_flag_out(flags), .shared_compare_value_out(shval),
    .shared_is_capture_out(is_cap), .pwm_a_out(pa), .pwm_b_out(pb),
    .accumulator_edge_irq_out(irq_e), .accumulator_overflow_irq_out(irq_o));

  pin_board i_board (.clock_in(clock_in), .rst_in(rst_in), .start_in(go),
    .count_in(npulse), .pin_out(pin), .busy_out(busy));

  // ****************************************
  // tasks and expectations
  // ****************************************
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic expire();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] e,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    be <= e;
    wdata <= {16'h0000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clock_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0) expire();
    @(posedge clock_in);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d, input logic [3:0] e = 4'h3);
    logic [31:0] q;
    bus(1'b1, a, e, d, q);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 4'h3, 16'h0000, q);
    check_val(q & msk, exp);
  endtask
  task automatic pulse(input logic [7:0] n);
    int k;
    k = 0;
    go <= 1'b1;
    npulse <= n;
    @(posedge clock_in);
    go <= 1'b0;
    do begin
      @(posedge clock_in);
      k++;
    end while (busy === 1'b1 && k < 1200);
    if (busy !== 1'b0) expire();
    repeat (5) @(posedge clock_in);
  endtask
  task automatic measure(input int w, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (w) begin
      @(posedge clock_in);
      ha += int'(pa === 1'b1);
      hb += int'(pb === 1'b1);
    end
  endtask
  function automatic logic [4:0] cmp_exp(logic [4:0] old, logic [4:0] msk, logic [4:0] dat,
                                         logic [4:0] tog);
    return ((old ^ tog) & ~msk) | (dat & msk);
  endfunction
  function automatic int duty_high(logic [7:0] du, int k);
    return int'(du) * (2 << k);
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [4:0]  m, d, o, f, ex;
    logic [15:0] v;
    logic [7:0]  du;
    int          ha, hb, k;
    void'($urandom(32'hED8B));
    ex = 5'h00;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rdm(OFS_FORCE_PWM_CONTROL, all_bits, 32'h0);
    rdm(OFS_DUTY, all_bits, 32'h0);
    rdm(OFS_ACC, 32'h3FFF, 32'h0);
    rdm(8'h30, all_bits, 32'h0);
    check_val({is_cap, oe}, 6'h00);
    wr16(OFS_DIR, 16'h001F);
    for (k = 0; k < 8; k++) begin
      m = 5'($urandom);
      d = 5'($urandom);
      o = 5'($urandom) & 5'h1E;
      wr16(OFS_ACTION, {3'b000, m, 3'b000, d});
      match <= o | 5'h01;
      @(posedge clock_in);
      match <= 5'h00;
      @(posedge clock_in);
      ex = cmp_exp(ex, m, d, o);
      check_val(pins, ex);
      check_val(flags, o | 5'h01);
      f = 5'($urandom);
      wr16(OFS_FORCE_PWM_CONTROL, {f[0], f[1], f[2], f[3], f[4], 11'h000}, 4'h2);
      @(posedge clock_in);
      check_val(flags, 5'h00);
      @(posedge clock_in);
      ex = cmp_exp(ex, f[0] ? m : 5'h00, d, f & 5'h1E);
      check_val(pins, ex);
      rdm(OFS_FORCE_PWM_CONTROL, 32'hF800, 32'h0);
    end
    v = 16'($urandom);
    wr16(OFS_SHARED, v);
    check_val(shval, v);
    wr16(OFS_ACC, 16'h2000);
    check_val({is_cap, oe[4]}, 2'b10);
    wr16(OFS_SHARED, ~v);
    rdm(OFS_SHARED, all_bits, {16'h0, v});
    frz <= 1'b1;
    wr16(OFS_SHARED, ~v);
    frz <= 1'b0;
    rdm(OFS_SHARED, all_bits, {16'h0, ~v});
    capv <= 16'($urandom);
    cap <= 1'b1;
    @(posedge clock_in);
    cap <= 1'b0;
    @(posedge clock_in);
    check_val(shval, capv);
    for (k = 0; k < 3; k++) begin
      du = 8'(1 + $urandom_range(40));
      wr16(OFS_ACC, (k == 2) ? 16'h1E00 : {4'h0, k[0], 11'h400});
      pulse(du);
      rdm(OFS_ACC, 32'hFF, {24'h0, du});
    end
    wr16(OFS_ACC, 16'h0CFF);
    wr16(OFS_FLAGS, 16'h0303);
    pulse(8'h01);
    rdm(OFS_ACC, 32'hFF, 32'h0);
    rdm(OFS_FLAGS, 32'h3, 32'h3);
    check_val({irq_e, irq_o}, 2'b11);
    wr16(OFS_FLAGS, 16'h0003, 4'h1);
    check_val({irq_e, irq_o}, 2'b00);
    wr16(OFS_FORCE_PWM_CONTROL, 16'h0200);
    repeat (3) @(posedge clock_in);
    check_val({pa, pb}, 2'b10);
    rdm(OFS_FORCE_PWM_CONTROL, 32'h0300, 32'h0200);
    for (k = 0; k < 3; k++) begin
      du = (k == 0) ? 8'($urandom) : ((k == 1) ? 8'h80 : 8'hFF);
      wr16(OFS_DUTY, {du, ~du});
      wr16(OFS_FORCE_PWM_CONTROL, 16'h0040 | 16'(k));
      repeat (1024 << k) @(posedge clock_in);
      rdm(OFS_DUTY, all_bits, {16'h0, du, ~du});
      rdm(OFS_DBUF, all_bits, {16'h0, du, ~du});
      measure(512 << k, ha, hb);
      check_val(ha, duty_high(du, k));
      check_val(hb, duty_high(~du, k));
    end
    wr16(OFS_DUTY, 16'h0200);
    wr16(OFS_FORCE_PWM_CONTROL, 16'h0060);
    frz <= 1'b1;
    wr16(OFS_PCNT, 16'h7FF0);
    frz <= 1'b0;
    measure(1024, ha, hb);
    check_val(ha, 32'd512);
    check_val(hb, 32'd0);
    wr16(OFS_FORCE_PWM_CONTROL, 16'h004A);
    measure(64, ha, hb);
    check_val(ha, 32'd8);
    wr16(OFS_FORCE_PWM_CONTROL, 16'h0342);
    check_val(pb, 1'b0);
    repeat (4200) @(posedge clock_in);
    measure(2048, ha, hb);
    check_val(ha, 32'd2048);
    check_val(hb, 32'd2048);
    complete_run();
  end
endmodule
`default_nettype wire
